// ==== core/taac_ctrl.sv ====
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "taac_params.svh"
// Contract
// - trace unstable enable lets trace-unstable tributaries raise aux rdi.
// - trace mismatch enable lets trace-mismatch tributaries raise aux rdi.
// - label unstable enable gates aux rdi from label-unstable state.
// - label mismatch enable gates aux rdi from label-mismatch state.
// - unequipped enable gates aux rdi from unequipped state.
// - lop disable blocks aux rdi for tributaries in loss of pointer.
// - ais disable blocks aux rdi for tributaries in incoming ais.
// - lom disable blocks aux rdi for tributaries in loss of multiframe.
// - label pdi enable reports path pdi on pdi label code.
// - unequipped pdi enable reports path pdi on unequipped label code.
// - ais pdi enable reports path pdi while tributary is in ais.
// - lop pdi enable reports path pdi while tributary is in lop.
// - ais insertion without idle forces every tributary byte to ones.
// - idle replaces payload with idle code, zeroes v5, overrides ais.
// - diagnostic bit inverts new data flag unless ais insertion set.
// - alarm enable raises events on lop and ais entry and exit.
// - pointer loss status bit reads current loss of pointer state.
// - pointer follower mode collapses the fifo dead-zone.
// - group field selects tu2, vt3, tu12 or tu11; ignored in tu3.
// - each unit register controls its tu3 or tu1 of tug2 one.
module taac_ctrl
	import taac_pkg::*;
#(
	parameter int UNITS = 3
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic [UNITS-1:0] tiu_i,
	input wire logic [UNITS-1:0] tim_i,
	input wire logic [UNITS-1:0] pslu_i,
	input wire logic [UNITS-1:0] pslm_i,
	input wire logic [UNITS-1:0] uneq_i,
	input wire logic [UNITS-1:0] ais_i,
	input wire logic [UNITS-1:0] lop_i,
	input wire logic [UNITS-1:0] lom_i,
	input wire logic [UNITS-1:0][2:0] label_i,
	input wire logic [UNITS-1:0][7:0] trib_data_i,
	input wire logic [UNITS-1:0] trib_v5_i,
	input wire logic [UNITS-1:0] trib_valid_i,
	output logic [UNITS-1:0][7:0] trib_data_o,
	output logic [UNITS-1:0] trib_valid_o,
	output logic [UNITS-1:0] auxiliary_remote_defect_o,
	output logic [UNITS-1:0] path_defect_report_o,
	output logic [UNITS-1:0] new_data_flag_invert_o,
	output logic [UNITS-1:0] pointer_follower_enable_o,
	output logic [UNITS-1:0][1:0] group_config_o,
	output logic [UNITS-1:0][2:0] active_tu_count_o,
	output logic [UNITS-1:0] tu3_mode_o,
	output logic [UNITS-1:0] alarm_event_o
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] auxiliary_remote_defect_ctl;
		logic [7:0] pdi_ctl;
		logic [7:0] misc;
		logic [UNITS-1:0][7:0] unit_cfg;
		logic [7:0] rdata;
		logic [UNITS-1:0] lop_prev;
		logic [UNITS-1:0] ais_prev;
		logic [UNITS-1:0] aux_rdi;
		logic [UNITS-1:0] pdi;
		logic [UNITS-1:0] ndf_inv;
		logic [UNITS-1:0] event_pulse;
		logic [UNITS-1:0][2:0] tu_count;
	} taac_core_state_type;

	taac_core_state_type state_reg;
	taac_core_state_type state_next;
	logic [UNITS-1:0] aux_rdi_comb;
	logic [UNITS-1:0] pdi_comb;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	// returns unit index plus one, zero when not a unit register
	function automatic logic [1:0] unit_hit(input logic [7:0] a);
		unit_hit = 2'h0;
		case (a)
			`TAAC_UNIT1_OFS: unit_hit = 2'h1;
			`TAAC_UNIT2_OFS: unit_hit = 2'h2;
			`TAAC_UNIT3_OFS: unit_hit = 2'h3;
			default: unit_hit = 2'h0;
		endcase
	endfunction

	// active tributaries per group layout
	function automatic logic [2:0] tu_count(input logic [1:0] g);
		case (taac_group_type'(g))
			TAAC_GRP_TU2: tu_count = 3'h1;
			TAAC_GRP_VT3: tu_count = 3'h2;
			TAAC_GRP_TU12: tu_count = 3'h3;
			TAAC_GRP_TU11: tu_count = 3'h4;
			default: tu_count = 3'h1;
		endcase
	endfunction

	// ----------------------------------------
	// per-unit alarm merge and byte insertion
	// ----------------------------------------
	for (genvar u = 0; u < UNITS; u++) begin : g_unit
		logic [7:0] cfg;
		assign cfg = state_reg.unit_cfg[u];

		taac_alarm_merge u_merge (
			.auxiliary_remote_defect_ctl_i(state_reg.auxiliary_remote_defect_ctl),
			.pdi_ctl_i(state_reg.pdi_ctl),
			.tiu_i(tiu_i[u]),
			.tim_i(tim_i[u]),
			.pslu_i(pslu_i[u]),
			.pslm_i(pslm_i[u]),
			.uneq_i(uneq_i[u]),
			.ais_i(ais_i[u]),
			.lop_i(lop_i[u]),
			.lom_i(lom_i[u]),
			.label_i(label_i[u]),
			.aux_rdi_o(aux_rdi_comb[u]),
			.pdi_o(pdi_comb[u])
		);

		// each instance serves the tributary of its own unit register
		taac_trib_insert u_insert (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.data_i(trib_data_i[u]),
			.v5_i(trib_v5_i[u]),
			.valid_i(trib_valid_i[u]),
			.ais_en_i(cfg[`TAAC_CFG_AIS]),
			.idle_en_i(cfg[`TAAC_CFG_IDLE]),
			.idle_code_i(state_reg.misc[`TAAC_MISC_IDLE_CODE_SELECT]),
			.data_o(trib_data_o[u]),
			.valid_o(trib_valid_o[u])
		);
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic [1:0] whit;
		logic [1:0] rhit;
		logic [7:0] rd_val;
		logic [1:0] grp;
		logic tu3;
		whit = unit_hit(addr_i);
		rhit = unit_hit(addr_i);
		rd_val = 8'h00;
		grp = 2'h0;
		tu3 = 1'b0;
		state_next = state_reg;

		// register writes; read-only and unused bits are masked to zero
		if (wr_i) begin
			case (addr_i)
				`TAAC_AUXILIARY_REMOTE_DEFECT_OFS: state_next.auxiliary_remote_defect_ctl = wdata_i;
				`TAAC_PDI_OFS: state_next.pdi_ctl =
					wdata_i & `TAAC_PDI_WMASK;
				`TAAC_MISC_OFS: state_next.misc =
					wdata_i & `TAAC_MISC_WMASK;
				default: begin
					if (whit != 2'h0 && 32'(whit) <= UNITS) begin
						state_next.unit_cfg[whit - 2'h1] =
							wdata_i & `TAAC_CFG_WMASK;
					end
				end
			endcase
		end

		// read mux; unmapped addresses read zero
		case (addr_i)
			`TAAC_AUXILIARY_REMOTE_DEFECT_OFS: rd_val = state_reg.auxiliary_remote_defect_ctl;
			`TAAC_PDI_OFS: rd_val = state_reg.pdi_ctl;
			`TAAC_MISC_OFS: rd_val = state_reg.misc;
			default: begin
				if (rhit != 2'h0 && 32'(rhit) <= UNITS) begin
					rd_val = state_reg.unit_cfg[rhit - 2'h1];
					// live loss of pointer status
					rd_val[`TAAC_CFG_POINTER_LOSS_STATUS] =
						lop_i[rhit - 2'h1];
				end
			end
		endcase
		// data stand only in the cycle after the read strobe
		state_next.rdata = rd_i ? rd_val : 8'h00;

		// per-unit status and derived controls
		for (int u = 0; u < UNITS; u++) begin
			tu3 = state_reg.misc[`TAAC_MISC_TU3 + u];
			grp = state_reg.unit_cfg[u][`TAAC_CFG_GRP_LO +: 2];
			state_next.aux_rdi[u] = aux_rdi_comb[u];
			state_next.pdi[u] = pdi_comb[u];
			// ais insertion masks the diagnostic inversion
			state_next.ndf_inv[u] =
				state_reg.unit_cfg[u][`TAAC_CFG_POINTER_DIAGNOSTIC_INVERT]
				& ~state_reg.unit_cfg[u][`TAAC_CFG_AIS];
			// tu3 carries one tributary, group layout is ignored
			state_next.tu_count[u] =
				tu3 ? 3'h1 : tu_count(grp);
			// entry or exit of lop or ais, masked by alarm enable
			state_next.event_pulse[u] =
				state_reg.unit_cfg[u][`TAAC_CFG_ALARM_INTERRUPT_ENABLE]
				& ((lop_i[u] ^ state_reg.lop_prev[u])
				| (ais_i[u] ^ state_reg.ais_prev[u]));
			state_next.lop_prev[u] = lop_i[u];
			state_next.ais_prev[u] = ais_i[u];
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	// prev samples reset low, but alarm enable resets low too, so a tributary
	// already in lop at release gives no entry event; accepted to keep reset simple
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= '0;
			state_reg.auxiliary_remote_defect_ctl <= `TAAC_AUXILIARY_REMOTE_DEFECT_RST;
			state_reg.pdi_ctl <= `TAAC_PDI_RST;
			state_reg.misc <= `TAAC_MISC_RST;
			state_reg.unit_cfg <= {UNITS{`TAAC_CFG_RST}};
			state_reg.tu_count <= {UNITS{3'h4}};
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign rdata_o = state_reg.rdata;
	assign auxiliary_remote_defect_o = state_reg.aux_rdi;
	assign path_defect_report_o = state_reg.pdi;
	assign new_data_flag_invert_o = state_reg.ndf_inv;
	assign alarm_event_o = state_reg.event_pulse;
	assign active_tu_count_o = state_reg.tu_count;
	assign tu3_mode_o = state_reg.misc[`TAAC_MISC_TU3 +: UNITS];

	// static controls straight from the unit registers
	for (genvar u = 0; u < UNITS; u++) begin : g_out
		// the pointer generator collapses its dead-zone on this
		assign pointer_follower_enable_o[u] =
			state_reg.unit_cfg[u][`TAAC_CFG_PF];
		assign group_config_o[u] =
			state_reg.unit_cfg[u][`TAAC_CFG_GRP_LO +: 2];
	end
endmodule // taac_ctrl

// ==== common/taac_params.svh ====
`ifndef TAAC_PARAMS_SVH
`define TAAC_PARAMS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define TAAC_AUXILIARY_REMOTE_DEFECT_OFS 8'h12
`define TAAC_PDI_OFS 8'h13
`define TAAC_MISC_OFS 8'h14
`define TAAC_UNIT1_OFS 8'h20
`define TAAC_UNIT2_OFS 8'h40
`define TAAC_UNIT3_OFS 8'h60
// ----------------------------------------
// auxiliary rdi control fields
// ----------------------------------------
`define TAAC_AUXILIARY_REMOTE_DEFECT_TIU 0
`define TAAC_AUXILIARY_REMOTE_DEFECT_TIM 1
`define TAAC_AUXILIARY_REMOTE_DEFECT_PSLU 2
`define TAAC_AUXILIARY_REMOTE_DEFECT_PSLM 3
`define TAAC_AUXILIARY_REMOTE_DEFECT_UNEQ 4
`define TAAC_AUXILIARY_REMOTE_DEFECT_NOAIS 5
`define TAAC_AUXILIARY_REMOTE_DEFECT_NOLOP 6
`define TAAC_AUXILIARY_REMOTE_DEFECT_NOLOM 7
// ----------------------------------------
// path defect control fields
// ----------------------------------------
`define TAAC_PDI_LABEL 3
`define TAAC_PDI_UNEQ 4
`define TAAC_PDI_AIS 5
`define TAAC_PDI_LOP 6
`define TAAC_PDI_WMASK 8'h78
// ----------------------------------------
// per-tributary fields
// ----------------------------------------
`define TAAC_CFG_AIS 0
`define TAAC_CFG_IDLE 1
`define TAAC_CFG_POINTER_DIAGNOSTIC_INVERT 2
`define TAAC_CFG_ALARM_INTERRUPT_ENABLE 3
`define TAAC_CFG_POINTER_LOSS_STATUS 4
`define TAAC_CFG_PF 5
`define TAAC_CFG_GRP_LO 6
`define TAAC_CFG_WMASK 8'hEF
// ----------------------------------------
// local misc register fields
// ----------------------------------------
`define TAAC_MISC_IDLE_CODE_SELECT 0
`define TAAC_MISC_TU3 1
`define TAAC_MISC_WMASK 8'h0F
// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define TAAC_AUXILIARY_REMOTE_DEFECT_RST 8'hE0
`define TAAC_PDI_RST 8'h00
`define TAAC_CFG_RST 8'hC0
`define TAAC_MISC_RST 8'h00
`define TAAC_LABEL_PDI 3'h6
`define TAAC_LABEL_UNEQ 3'h0
`endif

// ==== common/taac_pkg.sv ====
package taac_pkg;
	// tributary group layouts of the two-bit group field
	typedef enum logic [1:0] {
		TAAC_GRP_TU2 = 2'b00,
		TAAC_GRP_VT3 = 2'b01,
		TAAC_GRP_TU12 = 2'b10,
		TAAC_GRP_TU11 = 2'b11
	} taac_group_type;
endpackage

// ==== core/taac_alarm_merge.sv ====
`timescale 1ns/1ps
`include "taac_params.svh"
module taac_alarm_merge
	import taac_pkg::*;
(
	input wire logic [7:0] auxiliary_remote_defect_ctl_i,
	input wire logic [7:0] pdi_ctl_i,
	input wire logic tiu_i,
	input wire logic tim_i,
	input wire logic pslu_i,
	input wire logic pslm_i,
	input wire logic uneq_i,
	input wire logic ais_i,
	input wire logic lop_i,
	input wire logic lom_i,
	input wire logic [2:0] label_i,
	output logic aux_rdi_o,
	output logic pdi_o
);
	logic cause;
	logic veto;
	// ----------------------------------------
	// auxiliary rdi: enabled causes, vetoed by disables
	// ----------------------------------------
	assign cause = (auxiliary_remote_defect_ctl_i[`TAAC_AUXILIARY_REMOTE_DEFECT_TIU] & tiu_i)
		| (auxiliary_remote_defect_ctl_i[`TAAC_AUXILIARY_REMOTE_DEFECT_TIM] & tim_i)
		| (auxiliary_remote_defect_ctl_i[`TAAC_AUXILIARY_REMOTE_DEFECT_PSLU] & pslu_i)
		| (auxiliary_remote_defect_ctl_i[`TAAC_AUXILIARY_REMOTE_DEFECT_PSLM] & pslm_i)
		| (auxiliary_remote_defect_ctl_i[`TAAC_AUXILIARY_REMOTE_DEFECT_UNEQ] & uneq_i);
	assign veto = (auxiliary_remote_defect_ctl_i[`TAAC_AUXILIARY_REMOTE_DEFECT_NOLOP] & lop_i)
		| (auxiliary_remote_defect_ctl_i[`TAAC_AUXILIARY_REMOTE_DEFECT_NOAIS] & ais_i)
		| (auxiliary_remote_defect_ctl_i[`TAAC_AUXILIARY_REMOTE_DEFECT_NOLOM] & lom_i);
	assign aux_rdi_o = cause & ~veto;
	// ----------------------------------------
	// path defect report
	// ----------------------------------------
	assign pdi_o = (pdi_ctl_i[`TAAC_PDI_LABEL]
			& (label_i == `TAAC_LABEL_PDI))
		| (pdi_ctl_i[`TAAC_PDI_UNEQ]
			& (label_i == `TAAC_LABEL_UNEQ))
		| (pdi_ctl_i[`TAAC_PDI_AIS] & ais_i)
		| (pdi_ctl_i[`TAAC_PDI_LOP] & lop_i);
endmodule // taac_alarm_merge

// ==== core/taac_trib_insert.sv ====
`timescale 1ns/1ps
`include "taac_params.svh"
module taac_trib_insert
	import taac_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] data_i,
	input wire logic v5_i,
	input wire logic valid_i,
	input wire logic ais_en_i,
	input wire logic idle_en_i,
	input wire logic idle_code_i,
	output logic [7:0] data_o,
	output logic valid_o
);
	typedef struct packed {
		logic [7:0] data;
		logic valid;
	} taac_ins_state_type;
	taac_ins_state_type state_reg;
	taac_ins_state_type state_next;
	// ----------------------------------------
	// byte replacement, idle beats ais
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.valid = valid_i;
		if (idle_en_i) begin
			if (v5_i) begin
				state_next.data = 8'h00;
			end else begin
				state_next.data = {8{idle_code_i}};
			end
		end else if (ais_en_i) begin
			state_next.data = 8'hFF;
		end else begin
			state_next.data = data_i;
		end
	end
	// one stage so the output byte comes from a flop
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
	assign data_o = state_reg.data;
	assign valid_o = state_reg.valid;
endmodule // taac_trib_insert

// ==== sim/taac_ctrl_checker.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the control block
// ----------------------------------------
module taac_ctrl_checker #(
	parameter int UNITS = 3
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic [UNITS-1:0] ais_i,
	input wire logic [UNITS-1:0] lop_i,
	input wire logic [UNITS-1:0][2:0] label_i,
	input wire logic [UNITS-1:0][7:0] trib_data_i,
	input wire logic [UNITS-1:0] trib_v5_i,
	input wire logic [UNITS-1:0] trib_valid_i,
	input wire logic [UNITS-1:0][7:0] trib_data_o,
	input wire logic [UNITS-1:0] path_defect_report_o,
	input wire logic [UNITS-1:0] new_data_flag_invert_o,
	input wire logic [UNITS-1:0][1:0] group_config_o,
	input wire logic [UNITS-1:0] alarm_event_o
);
	logic [7:0] pdi_reg;
	logic [7:0] cfg_reg;
	logic pdi_exp;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// shadow registers, so nothing expected is read from the design
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pdi_reg <= 8'h00;
			cfg_reg <= 8'hC0;
		end else if (wr_i) begin
			if (addr_i == 8'h13) pdi_reg <= wdata_i;
			if (addr_i == 8'h20) cfg_reg <= wdata_i;
		end
	end
	// unit 0 path defect causes
	assign pdi_exp = (pdi_reg[3] & (label_i[0] == 3'h6))
		| (pdi_reg[4] & (label_i[0] == 3'h0))
		| (pdi_reg[5] & ais_i[0]) | (pdi_reg[6] & lop_i[0]);
	AST_READ_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data not zero outside read slot");
	AST_PDI: assert property (
		!$past(rst_i) |-> path_defect_report_o[0] == $past(pdi_exp))
		else $error("path defect report wrong");
	AST_EVENT: assert property (
		!$past(rst_i, 2) && !$past(rst_i) |-> alarm_event_o[0] ==
		($past(cfg_reg[3]) && ($past(lop_i[0]) != $past(lop_i[0], 2)
		|| $past(ais_i[0]) != $past(ais_i[0], 2))))
		else $error("alarm event wrong");
	AST_IDLE_V5: assert property (
		trib_valid_i[0] && trib_v5_i[0] && cfg_reg[1]
		|=> trib_data_o[0] == 8'h00)
		else $error("v5 not cleared in idle");
	AST_AIS_ONES: assert property (
		trib_valid_i[0] && cfg_reg[1:0] == 2'b01
		|=> trib_data_o[0] == 8'hFF)
		else $error("ais byte not all ones");
	AST_PASS: assert property (
		trib_valid_i[0] && cfg_reg[1:0] == 2'b00
		|=> trib_data_o[0] == $past(trib_data_i[0]))
		else $error("byte altered without insertion");
	AST_NDF: assert property (
		!$past(rst_i) |-> new_data_flag_invert_o[0] ==
		$past(cfg_reg[2] & ~cfg_reg[0]))
		else $error("flag invert wrong");
	AST_GROUP: assert property (group_config_o[0] == cfg_reg[7:6])
		else $error("group field wrong");
endmodule // taac_ctrl_checker

// ==== sim/taac_trib_src.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// tributary byte source
// ----------------------------------------
module taac_trib_src (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic slow_i,
	output logic [7:0] data_o,
	output logic v5_o,
	output logic valid_o
);
	logic [7:0] cnt_reg;
	// free-running byte count
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) cnt_reg <= 8'h00;
		else cnt_reg <= cnt_reg + 8'h01;
	end
	// slow mode leaves gaps; gaps carry a moving pattern, not stale data
	assign valid_o = !rst_i && !(slow_i && cnt_reg[0]);
	assign data_o = valid_o ? cnt_reg ^ 8'h5A : ~cnt_reg;
	assign v5_o = valid_o && cnt_reg[2:0] == 3'h0; // every eighth cycle
endmodule // taac_trib_src

// ==== sim/taac_ctrl_bench.sv ====
`timescale 1ns/1ps
module taac_ctrl_bench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic slow = 1'b0;
	logic s_v5, s_valid;
	logic [2:0] lbl = 3'h2;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic [7:0] alm = 8'h00;
	logic [7:0] rdata_o, s_data;
	logic [2:0][7:0] tdo;
	logic [2:0] tvo, aux, pdi, new_data_flag, pf, tu3, evt;
	logic [2:0][1:0] grp;
	logic [2:0][2:0] cnt;
	int error_cnt = 0;
	int num_checks = 0;
	// ----------------------------------------
	// clock, source and device
	// ----------------------------------------
	always #12.5 clk_i = ~clk_i;
	taac_trib_src src (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
		.data_o(s_data), .v5_o(s_v5), .valid_o(s_valid));
	// all units see the same alarms; only unit 0 is judged in detail
	taac_ctrl #(.UNITS(3)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .tiu_i({3{alm[0]}}), .tim_i({3{alm[1]}}),
		.pslu_i({3{alm[2]}}), .pslm_i({3{alm[3]}}), .uneq_i({3{alm[4]}}),
		.ais_i({3{alm[5]}}), .lop_i({3{alm[6]}}), .lom_i({3{alm[7]}}),
		.label_i({3{lbl}}), .trib_data_i({3{s_data}}),
		.trib_v5_i({3{s_v5}}), .trib_valid_i({3{s_valid}}),
		.trib_data_o(tdo), .trib_valid_o(tvo),
		.auxiliary_remote_defect_o(aux), .path_defect_report_o(pdi),
		.new_data_flag_invert_o(new_data_flag), .pointer_follower_enable_o(pf),
		.group_config_o(grp), .active_tu_count_o(cnt), .tu3_mode_o(tu3),
		.alarm_event_o(evt));
	// ----------------------------------------
	// bus and compare helpers
	// ----------------------------------------
	task automatic chk(input string n, input logic [7:0] g, e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rchk(input string n, input logic [7:0] a, e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(n, rdata_o, e);
	endtask
	// lets the edge's updates land before sampling
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		rchk("auxiliary_remote_defect rst", 8'h12, 8'hE0);
		rchk("pdi rst", 8'h13, 8'h00);
		rchk("unit1 rst", 8'h20, 8'hC0);
		rchk("unit2 rst", 8'h40, 8'hC0);
		rchk("unit3 rst", 8'h60, 8'hC0);
		wr(8'h13, 8'hFF);
		rchk("pdi mask", 8'h13, 8'h78);
		wr(8'h21, 8'h55);
		rchk("unmapped", 8'h21, 8'h00);
		wr(8'h20, 8'hFF);
		rchk("unit1 ro", 8'h20, 8'hEF);
		$display("test regs done");
	endtask
	// causes 0..4 enable alone; 5..7 veto a live trace cause
	task automatic t_aux;
		logic [7:0] m;
		for (int b = 0; b < 8; b++) begin
			m = 8'h01 << b;
			wr(8'h12, (b < 5) ? m : 8'h1F | m);
			@(posedge clk_i) alm <= (b < 5) ? m : m | 8'h01;
			tick(2);
			chk("aux set", {7'h00, aux[0]}, (b < 5) ? 8'h01 : 8'h00);
			wr(8'h12, (b < 5) ? 8'h1F ^ m : 8'h1F);
			tick(1);
			chk("aux flip", {7'h00, aux[0]}, (b < 5) ? 8'h00 : 8'h01);
		end
		$display("test aux done");
	endtask
	task automatic t_pdi;
		logic [7:0] m;
		for (int b = 3; b < 7; b++) begin
			m = 8'h01 << b;
			wr(8'h13, m);
			@(posedge clk_i) begin
				alm <= (b > 4) ? m : 8'h00;
				lbl <= (b == 3) ? 3'h6 : (b == 4) ? 3'h0 : 3'h2;
			end
			tick(2);
			chk("pdi on", {7'h00, pdi[0]}, 8'h01);
			wr(8'h13, 8'h78 ^ m);
			tick(1);
			chk("pdi off", {7'h00, pdi[0]}, 8'h00);
		end
		@(posedge clk_i) alm <= 8'h00;
		$display("test pdi done");
	endtask
	// pass, ais, idle zeros, idle ones, idle over ais
	task automatic t_stream;
		logic [7:0] d, e;
		logic v, vl;
		for (int k = 0; k < 5; k++) begin
			wr(8'h14, {7'h00, k == 3});
			wr(8'h20, (k == 4) ? 8'h03 : (k == 3) ? 8'h02 : 8'(k));
			slow <= k[0];
			repeat (12) begin
				@(posedge clk_i);
				d = s_data;
				v = s_v5;
				vl = s_valid;
				e = (k == 1) ? 8'hFF : d;
				if (k > 1) e = (v || k != 3) ? 8'h00 : 8'hFF;
				#1;
				chk("valid", {7'h00, tvo[0]}, {7'h00, vl});
				if (vl) chk("byte", tdo[0], e);
			end
		end
		$display("test stream done");
	endtask
	task automatic t_grp;
		for (int g = 0; g < 4; g++) begin
			wr(8'h20, {g[1:0], 6'h24});
			tick(1);
			chk("group", {6'h00, grp[0]}, {6'h00, g[1:0]});
			chk("tu count", {5'h00, cnt[0]}, 8'(g + 1));
			chk("pf ndf", {6'h00, pf[0], new_data_flag[0]}, 8'h03);
		end
		wr(8'h20, 8'h05);
		wr(8'h14, 8'h02);
		wr(8'h40, 8'h04);
		tick(1);
		chk("ndf units", {5'h00, new_data_flag}, 8'h02);
		chk("tu3 count", {4'h0, tu3[0], cnt[0]}, 8'h09);
		$display("test group done");
	endtask
	task automatic t_event;
		wr(8'h20, 8'h08);
		@(posedge clk_i) alm <= 8'h40;
		tick(1);
		chk("entry", {7'h00, evt[0]}, 8'h01);
		tick(1);
		chk("one pulse", {7'h00, evt[0]}, 8'h00);
		rchk("lop status", 8'h20, 8'h18);
		@(posedge clk_i) alm <= 8'h00;
		tick(1);
		chk("exit", {7'h00, evt[0]}, 8'h01);
		wr(8'h20, 8'h00);
		@(posedge clk_i) alm <= 8'h40;
		tick(1);
		chk("masked", {7'h00, evt[0]}, 8'h00);
		$display("test event done");
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// main sequence, reset held three cycles
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs;
		t_aux;
		t_pdi;
		t_stream;
		t_grp;
		t_event;
		test_done;
	end
	// the tests need well under 1000 cycles; 8000 means a hang
	initial begin
		#(25 * 8000);
		error_cnt++;
		test_done;
	end
endmodule // taac_ctrl_bench
bind taac_ctrl taac_ctrl_checker #(.UNITS(UNITS)) chk_u (.*);
